// ==== logic/wake_pkg.sv ====
// Operation
// - six 16-bit wrapping counters, channels 48-53
// - count switch or pulse inputs up to 300/s
// - reading a counter clears it to zero
// - humidity is hardware channel 54, shareable
// - 25 software channels each select hardware
// - four relays, each assigned any software channel; no relay logic here, only N_RELAY
// - wake every eight seconds, collect data
// - plug absent: sleep without serial reception
// - plug present: prompt, beep, listen one second
// - numeric character while listening enters menu
// - no character: sleep, listen next cycle
// - plug absent: ignore all received characters
// - 9600 baud, 8 bits, no parity, XON/XOFF
// - wake character aborts activity, sends menu
// - menu left only on escape character
// - finished task returns to menu, resends it
// - inapplicable option does nothing; here it resends the menu
// - escape cancels operation before commit
package wake_pkg;
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned BAUD         = 9600;
    localparam int unsigned BIT_CYC      = CLK_HZ / BAUD;
    localparam int unsigned LISTEN_MS    = 1000;
    localparam int unsigned LISTEN_CYC   = (CLK_HZ / 1000) * LISTEN_MS;
    localparam int unsigned DEB_US       = 1000;
    localparam int unsigned DEB_CYC      = (CLK_HZ / 1_000_000) * DEB_US;
    localparam int unsigned N_CNT        = 6;
    localparam int unsigned N_SW         = 25;
    localparam int unsigned N_RELAY      = 4;
    localparam logic [5:0]  HW_CNT_FIRST = 6'h30;
    localparam logic [5:0]  HW_CNT_LAST  = 6'h35;
    localparam logic [5:0]  HW_HUMID     = 6'h36;
    localparam logic [7:0]  CH_ESC       = 8'h1B;
    localparam logic [7:0]  CH_XON       = 8'h11;
    localparam logic [7:0]  CH_XOFF      = 8'h13;
    localparam logic [7:0]  CH_ZERO      = 8'h30;
    localparam logic [7:0]  CH_NINE      = 8'h39;
    localparam logic [7:0]  CH_OPT_LAST  = 8'h45;
    localparam logic [7:0]  CH_OPT_A     = 8'h41;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [2:0]  RX_SYNC_IDLE = 3'h7;
    localparam logic [1:0]  PLUG_IDLE    = 2'h3;
    localparam logic [5:0]  CNT_IN_IDLE  = 6'h3F;
    localparam logic [9:0]  TX_IDLE      = 10'h3FF;

    typedef enum logic [2:0] {
        ST_SLEEP  = 3'b000,
        ST_COLLECT= 3'b001,
        ST_PROMPT = 3'b010,
        ST_LISTEN = 3'b011,
        ST_MENU   = 3'b100,
        ST_TASK   = 3'b101
    } mode_t;
endpackage : wake_pkg

// ==== logic/wake_listen.sv ====
`timescale 1ns/1ps
module wake_listen #(
    parameter int unsigned BIT_CYCLES = wake_pkg::BIT_CYC,
    parameter int unsigned LISTEN_CYCLES = wake_pkg::LISTEN_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = wake_pkg::DEB_CYC
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        rtc_wake,
    input  wire logic        plug_detect_n,
    input  wire logic [5:0]  count_in,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             rx_enable,
    output logic             beep,
    output logic             collect_start,
    input  wire logic        collect_done,
    input  wire logic [4:0]  sw_sel,
    input  wire logic [5:0]  sw_map,
    input  wire logic        sw_read,
    output logic [15:0]      sw_data,
    output logic             sw_humid,
    input  wire logic [5:0]  hw_fitted,
    output logic [7:0]       host_char,
    output logic             host_char_valid,
    output logic [3:0]       menu_option,
    output logic             menu_option_valid,
    input  wire logic        task_done,
    output logic             task_cancel,
    output logic             menu_resend,
    output logic             menu_mode,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready
);
    localparam int unsigned NC = wake_pkg::N_CNT;

    typedef struct packed {
        logic [2:0]       rtc_s;
        logic [1:0]       plug_s;
        logic [2:0]       rx_s;
        logic [NC-1:0]    c_s1;
        logic [NC-1:0]    c_s2;
        logic [NC-1:0]    c_st;
        logic [NC*20-1:0] deb;
        logic [NC*16-1:0] cnt;
        wake_pkg::mode_t  mode;
        logic [31:0]      timer;
        logic             rx_busy;
        logic [15:0]      rx_t;
        logic [3:0]       rx_n;
        logic [7:0]       rx_sh;
        logic             tx_busy;
        logic [15:0]      tx_t;
        logic [3:0]       tx_n;
        logic [9:0]       tx_sh;
        logic             xoff;
        logic [15:0]      sw_data;
        logic             sw_humid;
        logic [7:0]       hc;
        logic             hcv;
        logic [3:0]       opt;
        logic             optv;
        logic             cancel;
        logic             resend;
        logic             collect;
        logic             beep;
    } state_t;

    state_t q, d;

    function automatic logic is_digit(input logic [7:0] c);
        return c >= wake_pkg::CH_ZERO && c <= wake_pkg::CH_NINE;
    endfunction : is_digit

    function automatic logic is_count_hw(input logic [5:0] h);
        return h >= wake_pkg::HW_CNT_FIRST && h <= wake_pkg::HW_CNT_LAST;
    endfunction : is_count_hw

    function automatic logic is_option_letter(input logic [7:0] c);
        return c >= wake_pkg::CH_OPT_A && c <= wake_pkg::CH_OPT_LAST;
    endfunction : is_option_letter

    // counts roll over from all ones to zero, never saturate
    function automatic logic [15:0] bump16(input logic [15:0] v);
        return (v == 16'hFFFF) ? 16'h0000 : v + 16'h0001;
    endfunction : bump16

    // digit options always apply; letter options need fitted hardware
    function automatic logic option_fitted(input logic [3:0] o,
                                           input logic [5:0] f);
        logic ok;
        ok = 1'b1;
        if (o >= 4'hA) begin
            ok = f[3'(o - 4'hA)];
        end
        return ok;
    endfunction : option_fitted

    logic       rx_got;
    logic [7:0] rx_byte;
    logic [2:0] ci;
    logic [7:0] opt_raw;

    always_comb begin
        d = q;
        rx_got = 1'b0;
        rx_byte = q.rx_sh;
        ci = 3'h0;
        opt_raw = 8'h00;
        d.rtc_s   = {q.rtc_s[1:0], rtc_wake};
        d.plug_s  = {q.plug_s[0], plug_detect_n};
        d.rx_s    = {q.rx_s[1:0], rx_pin};
        d.c_s1    = count_in;
        d.c_s2    = q.c_s1;
        d.hcv     = 1'b0;
        d.optv    = 1'b0;
        d.cancel  = 1'b0;
        d.resend  = 1'b0;
        d.collect = 1'b0;
        d.beep    = (q.mode == wake_pkg::ST_PROMPT);
        // debounce: input must hold steady before its new level counts
        for (int i = 0; i < NC; i++) begin
            if (q.c_s2[i] == q.c_st[i]) begin
                d.deb[i*20 +: 20] = 20'h00000;
            end else if (q.deb[i*20 +: 20] >= 20'(DEBOUNCE_CYCLES)) begin
                d.deb[i*20 +: 20] = 20'h00000;
                d.c_st[i] = q.c_s2[i];
                if (!q.c_s2[i]) begin
                    // closure pulls low; count once per closure
                    d.cnt[i*16 +: 16] = bump16(q.cnt[i*16 +: 16]);
                end
            end else begin
                d.deb[i*20 +: 20] = q.deb[i*20 +: 20] + 20'h00001;
            end
        end
        // software channel read path
        if (sw_read) begin
            d.sw_humid = (sw_map == wake_pkg::HW_HUMID);
            d.sw_data  = 16'h0000;
            // numbers past the last software channel read nothing
            if (is_count_hw(sw_map) && sw_sel < 5'(wake_pkg::N_SW)) begin
                ci = 3'(sw_map - wake_pkg::HW_CNT_FIRST);
                d.sw_data = q.cnt[ci*16 +: 16];
                // a count landing on the read is lost; clear wins here
                d.cnt[ci*16 +: 16] = wake_pkg::CNT_RESET;
            end
        end
        // receiver, 8N1, only while the line is powered
        if (!rx_enable) begin
            d.rx_busy = 1'b0;
            // a host that went away can never send XON; do not stall tx
            d.xoff = 1'b0;
        end else if (!q.rx_busy) begin
            if (!q.rx_s[2]) begin
                d.rx_busy = 1'b1;
                d.rx_t = 16'(BIT_CYCLES / 2);
                d.rx_n = 4'h0;
            end
        end else if (q.rx_t != 16'h0000) begin
            d.rx_t = q.rx_t - 16'h0001;
        end else begin
            d.rx_t = 16'(BIT_CYCLES - 1);
            d.rx_n = q.rx_n + 4'h1;
            if (q.rx_n == 4'h0 && q.rx_s[2]) begin
                // line high again at mid start bit: a glitch, not a frame
                d.rx_busy = 1'b0;
            end
            if (q.rx_n >= 4'h1 && q.rx_n <= 4'h8) begin
                d.rx_sh = {q.rx_s[2], q.rx_sh[7:1]};
            end
            if (q.rx_n == 4'h9) begin
                d.rx_busy = 1'b0;
                // a low stop bit is a framing error; the byte is dropped
                rx_got = q.rx_s[2];
            end
        end
        if (rx_got) begin
            if (rx_byte == wake_pkg::CH_XOFF) begin
                d.xoff = 1'b1;
            end else if (rx_byte == wake_pkg::CH_XON) begin
                d.xoff = 1'b0;
            end else begin
                d.hc  = rx_byte;
                d.hcv = 1'b1;
            end
        end
        // transmitter; xoff holds new bytes, never one in flight
        if (!q.tx_busy) begin
            if (tx_valid && !q.xoff) begin
                d.tx_busy = 1'b1;
                d.tx_sh = {1'b1, tx_data, 1'b0};
                d.tx_t = 16'(BIT_CYCLES - 1);
                d.tx_n = 4'h0;
            end
        end else if (q.tx_t != 16'h0000) begin
            d.tx_t = q.tx_t - 16'h0001;
        end else begin
            d.tx_t = 16'(BIT_CYCLES - 1);
            d.tx_sh = {1'b1, q.tx_sh[9:1]};
            d.tx_n = q.tx_n + 4'h1;
            if (q.tx_n == 4'h9) begin
                d.tx_busy = 1'b0;
            end
        end
        // sequencer
        case (q.mode)
            wake_pkg::ST_SLEEP: begin
                if (q.rtc_s[1] && !q.rtc_s[2]) begin
                    d.mode = wake_pkg::ST_COLLECT;
                    d.collect = 1'b1;
                end
            end
            wake_pkg::ST_COLLECT: begin
                if (collect_done) begin
                    if (q.plug_s[1]) begin
                        d.mode = wake_pkg::ST_SLEEP;
                    end else begin
                        d.mode = wake_pkg::ST_PROMPT;
                        d.resend = 1'b1;
                    end
                end
            end
            wake_pkg::ST_PROMPT: begin
                d.mode = wake_pkg::ST_LISTEN;
                d.timer = 32'(LISTEN_CYCLES);
            end
            wake_pkg::ST_LISTEN: begin
                if (rx_got && is_digit(rx_byte)) begin
                    d.mode = wake_pkg::ST_MENU;
                    d.cancel = 1'b1;
                    d.resend = 1'b1;
                end else if (q.timer == 32'h0) begin
                    d.mode = wake_pkg::ST_SLEEP;
                end else begin
                    d.timer = q.timer - 32'h1;
                end
            end
            wake_pkg::ST_MENU: begin
                if (rx_got) begin
                    opt_raw = rx_byte - wake_pkg::CH_OPT_A + 8'h0A;
                    if (rx_byte == wake_pkg::CH_ESC) begin
                        d.mode = wake_pkg::ST_SLEEP;
                    end else if (is_digit(rx_byte)) begin
                        d.opt = 4'(rx_byte - wake_pkg::CH_ZERO);
                        d.optv = 1'b1;
                        d.mode = wake_pkg::ST_TASK;
                    end else if (is_option_letter(rx_byte)) begin
                        // an unfitted option only redisplays the menu
                        if (option_fitted(opt_raw[3:0], hw_fitted)) begin
                            d.opt = opt_raw[3:0];
                            d.optv = 1'b1;
                            d.mode = wake_pkg::ST_TASK;
                        end else begin
                            d.resend = 1'b1;
                        end
                    end else begin
                        d.resend = 1'b1;
                    end
                end
            end
            wake_pkg::ST_TASK: begin
                if (rx_got && rx_byte == wake_pkg::CH_ESC) begin
                    d.cancel = 1'b1;
                    d.mode = wake_pkg::ST_MENU;
                    d.resend = 1'b1;
                end else if (task_done) begin
                    d.mode = wake_pkg::ST_MENU;
                    d.resend = 1'b1;
                end
            end
            default: d.mode = wake_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            // pins rest high: start there so no false edge follows reset
            q.rx_s  <= wake_pkg::RX_SYNC_IDLE;
            q.c_s1  <= wake_pkg::CNT_IN_IDLE;
            q.c_s2  <= wake_pkg::CNT_IN_IDLE;
            q.c_st  <= wake_pkg::CNT_IN_IDLE;
            q.plug_s <= wake_pkg::PLUG_IDLE;
            q.tx_sh <= wake_pkg::TX_IDLE;
            q.mode  <= wake_pkg::ST_SLEEP;
        end else begin
            q <= d;
        end
    end

    // receiver powered only with plug grounded and listening or awake
    assign rx_enable = !q.plug_s[1] &&
        (q.mode == wake_pkg::ST_LISTEN || q.mode == wake_pkg::ST_MENU ||
         q.mode == wake_pkg::ST_TASK);
    assign tx_pin            = q.tx_sh[0];
    assign tx_ready          = !q.tx_busy && !q.xoff;
    assign beep              = q.beep;
    assign collect_start     = q.collect;
    assign sw_data           = q.sw_data;
    assign sw_humid          = q.sw_humid;
    assign host_char         = q.hc;
    assign host_char_valid   = q.hcv;
    // option strobes are only raised for options the unit can serve
    assign menu_option       = q.opt;
    assign menu_option_valid = q.optv;
    assign task_cancel       = q.cancel;
    assign menu_resend       = q.resend;
    assign menu_mode = (q.mode == wake_pkg::ST_MENU ||
                        q.mode == wake_pkg::ST_TASK);
endmodule : wake_listen

// ==== dv/wake_listen_assertions.sv ====
`timescale 1ns/1ps
module wake_listen_assertions #(
    parameter int unsigned LISTEN_CYCLES   = 200,
    parameter int unsigned DEBOUNCE_CYCLES = 4
) (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        plug_detect_n,
    input wire logic        rx_enable,
    input wire logic        beep,
    input wire logic [5:0]  sw_map,
    input wire logic        sw_read,
    input wire logic [15:0] sw_data,
    input wire logic        sw_humid,
    input wire logic [7:0]  host_char,
    input wire logic        host_char_valid,
    input wire logic        task_done,
    input wire logic        menu_resend,
    input wire logic        menu_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_digit;
        host_char_valid && !$past(menu_mode) && host_char >= wake_pkg::CH_ZERO
            && host_char <= wake_pkg::CH_NINE;
    endsequence
    sequence s_enter;
        ##[0:3] menu_mode;
    endsequence
    a_beep_pulse: assert property (beep |=> !beep)
        else $error("beep longer than one cycle");
    a_beep_plug: assert property (beep |-> !plug_detect_n)
        else $error("beep without plug");
    a_beep_listen: assert property (beep |-> ##[0:2] rx_enable)
        else $error("no listening after beep");
    a_rx_gated: assert property (host_char_valid |-> $past(rx_enable))
        else $error("character taken with receiver off");
    a_digit_menu: assert property (s_digit |-> s_enter)
        else $error("digit did not open menu");
    a_digit_resend: assert property (s_digit |-> ##[0:3] menu_resend)
        else $error("menu not sent on wake");
    a_menu_stays: assert property (menu_mode && host_char_valid
        && host_char != wake_pkg::CH_ESC |=> menu_mode)
        else $error("menu left without escape");
    a_task_resend: assert property (task_done && menu_mode
        |-> ##[1:3] menu_resend)
        else $error("menu not resent after task");
    a_humid_flag: assert property (sw_read |=>
        sw_humid == ($past(sw_map) == wake_pkg::HW_HUMID))
        else $error("humidity flag wrong");
    a_data_holds: assert property (!sw_read |=> $stable(sw_data))
        else $error("count output moved without read");
endmodule : wake_listen_assertions

bind wake_listen wake_listen_assertions #(
    .LISTEN_CYCLES(LISTEN_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) i_wake_listen_assertions (
    .clock(clock), .reset_n(reset_n), .plug_detect_n(plug_detect_n),
    .rx_enable(rx_enable), .beep(beep), .sw_map(sw_map),
    .sw_read(sw_read), .sw_data(sw_data), .sw_humid(sw_humid),
    .host_char(host_char), .host_char_valid(host_char_valid),
    .task_done(task_done), .menu_resend(menu_resend),
    .menu_mode(menu_mode)
);

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
module host_model #(
    parameter int unsigned BIT_CYCLES = wake_pkg::BIT_CYC
) (
    input wire logic clock,
    output logic     line
);
    // rs232 rests at mark between frames
    initial line = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            #1 line = f[i];
            repeat (BIT_CYCLES - 1) @(posedge clock);
        end
    endtask : send_byte
endmodule : host_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned BIT = 40;
    logic        clock, reset_n, rtc_wake, plug_detect_n, collect_done;
    logic        sw_read, task_done, tx_valid, rx_pin, tx_pin, rx_enable;
    logic        beep, collect_start, sw_humid, host_char_valid, tx_ready;
    logic        menu_option_valid, task_cancel, menu_resend, menu_mode;
    logic [5:0]  count_in, sw_map, hw_fitted;
    logic [4:0]  sw_sel;
    logic [7:0]  tx_data, host_char;
    logic [15:0] sw_data;
    logic [3:0]  menu_option, last_opt;
    int          num_errors, n_checks, n_resend, n_cancel;

    // short bit time keeps the run small; listen outlasts one frame
    wake_listen #(.BIT_CYCLES(BIT), .LISTEN_CYCLES(1000),
        .DEBOUNCE_CYCLES(4)) i_wake_listen (
        .clock(clock), .reset_n(reset_n), .rtc_wake(rtc_wake),
        .plug_detect_n(plug_detect_n), .count_in(count_in), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .rx_enable(rx_enable), .beep(beep),
        .collect_start(collect_start), .collect_done(collect_done),
        .sw_sel(sw_sel), .sw_map(sw_map), .sw_read(sw_read),
        .sw_data(sw_data), .sw_humid(sw_humid), .hw_fitted(hw_fitted),
        .host_char(host_char), .host_char_valid(host_char_valid),
        .menu_option(menu_option), .menu_option_valid(menu_option_valid),
        .task_done(task_done), .task_cancel(task_cancel),
        .menu_resend(menu_resend), .menu_mode(menu_mode),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
    );
    host_model #(.BIT_CYCLES(BIT)) i_host_model (
        .clock(clock), .line(rx_pin));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (menu_resend) n_resend <= n_resend + 1;
        if (task_cancel) n_cancel <= n_cancel + 1;
        if (menu_option_valid) last_opt <= menu_option;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic rd(input logic [5:0] m);
        sw_map = m;
        sw_read = 1'b1;
        step(1);
        sw_read = 1'b0;
        step(1);
    endtask : rd
    task automatic send(input logic [7:0] b);
        i_host_model.send_byte(b);
        step(20);
    endtask : send
    task automatic t_count;
        for (int n = 0; n < 3; n++) begin
            count_in[2] = 1'b0;
            step(12);
            count_in[2] = 1'b1;
            step(12);
        end
        sw_sel = 5'h19;
        rd(6'h32);
        check(sw_data, 16'h0000);
        sw_sel = 5'h00;
        rd(6'h32);
        check(sw_data, 16'h0003);
        rd(6'h32);
        check(sw_data, 16'h0000);
        rd(6'h30);
        check(sw_data, 16'h0000);
        check(sw_humid, 1'b0);
        rd(wake_pkg::HW_HUMID);
        check(sw_humid, 1'b1);
    endtask : t_count
    task automatic wake(input logic plug);
        int k;
        plug_detect_n = plug;
        step(5);
        rtc_wake = 1'b1;
        for (k = 0; k < 50 && collect_start !== 1'b1; k++) step(1);
        check(collect_start, 1'b1);
        rtc_wake = 1'b0;
        collect_done = 1'b1;
        step(1);
        collect_done = 1'b0;
        for (k = 0; k < 50 && beep !== 1'b1; k++) step(1);
        check(beep, !plug);
        step(3);
        check(rx_enable, !plug);
    endtask : wake
    task automatic t_tx;
        int k;
        check(tx_ready, 1'b1);
        tx_data = 8'h41;
        tx_valid = 1'b1;
        for (k = 0; k < 50 && tx_ready !== 1'b1; k++) step(1);
        step(1);
        tx_valid = 1'b0;
        step(BIT / 2);
        check(tx_pin, 1'b0);
        step(BIT);
        check(tx_pin, 1'b1);
        step(BIT);
        check(tx_pin, 1'b0);
        step(BIT * 7);
        check(tx_pin, 1'b1);
    endtask : t_tx
    task automatic t_menu;
        int r, c;
        wake(1'b0);
        r = n_resend;
        send(wake_pkg::CH_NINE);
        check(menu_mode, 1'b1);
        check(n_resend, r + 1);
        send(wake_pkg::CH_OPT_A);
        check(last_opt, 4'hA);
        c = n_cancel;
        send(wake_pkg::CH_ESC);
        check(n_cancel, c + 1);
        check(menu_mode, 1'b1);
        hw_fitted = 6'h3D;
        r = n_resend;
        send(8'h42);
        check(n_resend, r + 1);
        check(last_opt, 4'hA);
        check(menu_mode, 1'b1);
        hw_fitted = 6'h3F;
        send(8'h33);
        r = n_resend;
        task_done = 1'b1;
        step(1);
        task_done = 1'b0;
        step(5);
        check(n_resend, r + 1);
        send(wake_pkg::CH_ESC);
        check(menu_mode, 1'b0);
        check(host_char, 16'(wake_pkg::CH_ESC));
    endtask : t_menu
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    initial begin
        reset_n = 1'b0;
        {rtc_wake, collect_done, sw_read, task_done, tx_valid} = 5'h00;
        plug_detect_n = 1'b1;
        count_in = 6'h3F;
        sw_map = 6'h00;
        sw_sel = 5'h00;
        hw_fitted = 6'h3F;
        tx_data = 8'h00;
        last_opt = 4'h0;
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        step(2);
        check(tx_pin, 1'b1);
        check(menu_mode, 1'b0);
        t_count;
        t_tx;
        wake(1'b1);
        send(wake_pkg::CH_ZERO);
        check(menu_mode, 1'b0);
        wake(1'b0);
        step(1100);
        check(rx_enable, 1'b0);
        check(menu_mode, 1'b0);
        t_menu;
        complete_run;
    end
    // whole run is about 5k cycles, mostly serial frames
    initial begin
        #100_000;
        num_errors++;
        complete_run;
    end
endmodule : tb_top
